//--- design/cell_balance_pkg.sv
package cell_balance_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ             = 25_000_000;
   localparam int BAL_TIMEOUT_S      = 20;
   localparam int BAL_TIMEOUT_CYCLES = BAL_TIMEOUT_S * CLK_HZ;
   localparam int SETTLE_MAX_MS      = 64;
   localparam int MS_CYCLES          = CLK_HZ / 1000;
   localparam int SLOT_CYCLES_DEF    = 64;
   localparam int SLOTS_PER_ROUND    = 8;
   localparam int NUM_CELLS_DEF      = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_BAL_CMD = 8'h04;
   localparam logic [7:0] OFS_MODE    = 8'h08;
   localparam logic [7:0] OFS_ALARM   = 8'h0c;

   // Field positions
   localparam int CFG_SKIP_LSB  = 0;
   localparam int CFG_SPEED_LSB = 2;
   localparam int CFG_DELAY_LSB = 4;
   localparam int ALM_FLAG_BIT  = 0;
   localparam int ALM_PEND_BIT  = 1;
   localparam int ALM_OV_BIT    = 2;
   localparam int ALM_UV_BIT    = 3;

   // Reset values
   localparam logic [1:0] SKIP_RESET  = 2'h0;
   localparam logic [1:0] SPEED_RESET = 2'h0;
   localparam logic [2:0] DELAY_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_DEEP} power_mode_e;
   typedef enum logic [1:0] {BAL_OFF, BAL_PENDING, BAL_ON} bal_state_e;
   typedef enum logic {SCH_RUN, SCH_SETTLE} sched_e;

   // Fixed settle table, milliseconds per code
   function automatic int settle_ms(input logic [2:0] code);
      settle_ms = (code == 3'h0) ? 0 : (SETTLE_MAX_MS >> (3'h7 - code));
   endfunction

endpackage

//--- design/slot_timer.sv
`timescale 1ns/1ns
module slot_timer
   import cell_balance_pkg::*;
#(
   parameter int SLOT_CYCLES = SLOT_CYCLES_DEF,
   parameter int SLOTS       = SLOTS_PER_ROUND
)(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     run,
   output logic [$clog2(SLOTS)-1:0]      slot_idx,
   output logic                          slot_last,
   output logic                          round_end
);
   localparam int CW = $clog2(SLOT_CYCLES);
   localparam int SW = $clog2(SLOTS);
   localparam logic [CW-1:0] CYC_LAST  = CW'(SLOT_CYCLES - 1);
   localparam logic [SW-1:0] SLOT_LAST = SW'(SLOTS - 1);

   typedef struct packed {
      logic [CW-1:0] cyc;
      logic [SW-1:0] slot;
   } state_s;

   state_s s_reg;
   state_s s_next;

   assign slot_idx  = s_reg.slot;
   assign slot_last = (s_reg.slot == SLOT_LAST);
   assign round_end = run && slot_last && (s_reg.cyc == CYC_LAST);

   always_comb
   begin
      s_next = s_reg;
      // Halting keeps slot widths intact while the settle delay stretches the loop
      if (run)
      begin
         if (s_reg.cyc == CYC_LAST)
         begin
            s_next.cyc  = '0;
            s_next.slot = slot_last ? '0 : s_reg.slot + 1'b1;
         end
         else
            s_next.cyc = s_reg.cyc + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
endmodule

//--- design/settle_timer.sv
`timescale 1ns/1ns
module settle_timer
#(
   parameter int W = 21
)(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic             busy,
   output logic             done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } state_s;

   state_s s_reg;
   state_s s_next;

   assign busy = (s_reg.cnt != '0);
   assign done = (s_reg.cnt == W'(1));

   always_comb
   begin
      s_next = s_reg;
      if (load)
         s_next.cnt = load_val;
      else if (busy)
         s_next.cnt = s_reg.cnt - 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
endmodule

//--- design/cell_balance_scheduler.sv
// Operation
// (R1) Ratio 0: skip measurements every second round
// (R2) Ratio 1: skip three of four rounds
// (R3) Ratio 2: skip seven of eight rounds
// (R4) Ratio 3: skip fifteen of sixteen rounds
// (R5) Skipped slots become equal-length idle slots
// (R6) Bypass off one slot before measuring round
// (R7) Check overvoltage/undervoltage only on new data
// (R8) Start waits for current round to finish
// (R9) Loop speed or skip ratio, never both
// (R10) Voltage alert stops balancing at once
// (R11) Balancing blocks sleep; start wakes sleep
// (R12) Start ignored in deep low-power mode
// (R13) Entering deep low-power ends balancing
// (R14) Command read returns requested mask immediately
// (R15) Active flag set at start, cleared on stop
// (R16) Active flag stays set during measurement pauses
// (R17) Settle delay after bypass off, before measuring
// (R18) Settle delay stretches interval between rounds
// (R19) Twenty second timer, restarted per command
// (R20) Host writes zero mask to stop
// (R21) Bypass off while cells or shared slot measured
// (R22) Round counter modulo ratio; zero is measuring
// (R23) Settle code maps to fixed delay table
`timescale 1ns/1ns
module cell_balance_scheduler
   import cell_balance_pkg::*;
#(
   parameter int NUM_CELLS   = NUM_CELLS_DEF,
   parameter int SLOT_CYCLES = SLOT_CYCLES_DEF,
   parameter int TIMEOUT_CYC = BAL_TIMEOUT_CYCLES,
   parameter int MS_CYC      = MS_CYCLES
)(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 new_meas_valid,
   input  wire logic                 cell_overvoltage,
   input  wire logic                 cell_undervoltage,
   output logic [NUM_CELLS-1:0]      bypass_en,
   output logic                      measure_slot,
   output logic                      idle_slot,
   output logic [1:0]                power_mode,
   output logic                      balancing_active_flag
);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam int SW = $clog2(SETTLE_MAX_MS * MS_CYC + 1);
   localparam logic [TW-1:0] TIMEOUT_LOAD = TW'(TIMEOUT_CYC);

   typedef struct packed {
      logic [1:0]           skip;
      logic [1:0]           speed;
      logic [2:0]           delay;
      logic [NUM_CELLS-1:0] mask;
      bal_state_e           bal;
      power_mode_e          mode;
      sched_e               sched;
      logic [3:0]           round;
      logic [TW-1:0]        tmr;
      logic                 ov;
      logic                 uv;
      logic                 was_on;
      logic [NUM_CELLS-1:0] bypass;
      logic                 meas;
      logic                 idle;
      logic                 flag;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } state_s;

   state_s s_reg;
   state_s s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Wrap mask of the round counter for the schedule in force
   function automatic logic [3:0] wrap_mask(input logic bal_on, input logic [1:0] skip,
                                            input logic [1:0] speed);
      // (R9) exclusive settings
      if (bal_on)
         // (R1) (R2) (R3) (R4) skip ratio
         wrap_mask = 4'((5'h02 << skip) - 5'h01);
      else
         wrap_mask = 4'((5'h01 << speed) - 5'h01);
   endfunction

   function automatic logic addr_hit(input logic [7:0] a);
      unique case (a)
         OFS_CONFIG,
         OFS_BAL_CMD,
         OFS_MODE,
         OFS_ALARM: addr_hit = 1'b1;
         default:   addr_hit = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Slot and settle timing

   logic                               run;
   logic                               slot_last;
   logic                               round_end;
   logic                               settle_load;
   logic [SW-1:0]                      settle_cyc;
   logic                               settle_done;

   // Deep low-power freezes the loop; sleep keeps measuring
   assign run = (s_reg.sched == SCH_RUN) && (s_reg.mode != MODE_DEEP);

   // (R23) code to delay table
   assign settle_cyc = SW'(settle_ms(s_reg.delay) * MS_CYC);

   slot_timer #(
      .SLOT_CYCLES (SLOT_CYCLES),
      .SLOTS       (SLOTS_PER_ROUND)
   ) u_slot (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (run),
      .slot_idx  (),
      .slot_last (slot_last),
      .round_end (round_end)
   );

   settle_timer #(
      .W (SW)
   ) u_settle (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (settle_load),
      .load_val (settle_cyc),
      .busy     (),
      .done     (settle_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic       access;
   logic       wr;
   logic [3:0] wmask;
   logic       cur_meas;
   logic       next_meas;
   logic [3:0] round_inc;

   assign access    = psel && penable;
   assign wr        = access && s_reg.pready && pwrite;
   assign wmask     = wrap_mask(s_reg.bal == BAL_ON, s_reg.skip, s_reg.speed);
   // Counter bits above the wrap mask are dropped so a ratio change takes effect at once
   assign round_inc = (s_reg.round + 4'h1) & wmask;
   // (R22) counter at zero is the measuring round
   assign cur_meas  = ((s_reg.round & wmask) == 4'h0);
   assign next_meas = (round_inc == 4'h0);
   assign settle_load = round_end && next_meas && s_reg.was_on && (settle_cyc != '0);

   ////////////////////////////////////////////////////////////////////////////
   // State update

   always_comb
   begin
      s_next         = s_reg;
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;

      // One wait state so read data leaves a flip-flop
      if (access && !s_reg.pready)
      begin
         s_next.pready  = 1'b1;
         s_next.pslverr = !addr_hit(paddr);
         s_next.prdata  = '0;
         unique case (paddr)
            OFS_CONFIG:
            begin
               s_next.prdata[CFG_SKIP_LSB +: 2]  = s_reg.skip;
               s_next.prdata[CFG_SPEED_LSB +: 2] = s_reg.speed;
               s_next.prdata[CFG_DELAY_LSB +: 3] = s_reg.delay;
            end
            // (R14) requested mask reads back before start
            OFS_BAL_CMD: s_next.prdata[NUM_CELLS-1:0] = s_reg.mask;
            OFS_MODE:    s_next.prdata[1:0] = s_reg.mode;
            OFS_ALARM:
            begin
               s_next.prdata[ALM_FLAG_BIT] = s_reg.flag;
               s_next.prdata[ALM_PEND_BIT] = (s_reg.bal == BAL_PENDING);
               s_next.prdata[ALM_OV_BIT]   = s_reg.ov;
               s_next.prdata[ALM_UV_BIT]   = s_reg.uv;
            end
            default:     s_next.prdata = '0;
         endcase
      end

      // Counts through the pending wait too, so a start that never lands still expires
      // (R19) timeout ends balancing
      if (s_reg.bal != BAL_OFF)
      begin
         if (s_reg.tmr <= TW'(1))
         begin
            s_next.bal  = BAL_OFF;
            s_next.mask = '0;
         end
         else
            s_next.tmr = s_reg.tmr - 1'b1;
      end

      // (R8) pending start takes effect at round end
      if (s_reg.bal == BAL_PENDING && round_end)
         s_next.bal = BAL_ON;

      if (wr)
      begin
         unique case (paddr)
            OFS_CONFIG:
            begin
               s_next.skip  = pwdata[CFG_SKIP_LSB +: 2];
               s_next.speed = pwdata[CFG_SPEED_LSB +: 2];
               s_next.delay = pwdata[CFG_DELAY_LSB +: 3];
            end
            OFS_BAL_CMD:
            begin
               // (R12) ignored in deep low-power mode
               if (s_reg.mode == MODE_DEEP)
                  s_next.mask = s_reg.mask;
               // (R20) zero mask stops balancing
               else if (pwdata[NUM_CELLS-1:0] == '0)
               begin
                  s_next.bal  = BAL_OFF;
                  s_next.mask = '0;
               end
               else
               begin
                  s_next.mask = pwdata[NUM_CELLS-1:0];
                  // (R19) every accepted nonzero command restarts timer
                  s_next.tmr  = TIMEOUT_LOAD;
                  if (s_reg.bal == BAL_OFF)
                     s_next.bal = BAL_PENDING;
                  // (R11) start wakes from sleep
                  s_next.mode = MODE_NORMAL;
               end
            end
            OFS_MODE:
            begin
               // (R13) deep entry terminates balancing
               if (pwdata[1:0] == MODE_DEEP)
               begin
                  s_next.mode = MODE_DEEP;
                  s_next.bal  = BAL_OFF;
                  s_next.mask = '0;
               end
               // (R11) sleep refused while balancing
               else if (pwdata[1:0] == MODE_SLEEP)
               begin
                  if (s_reg.bal == BAL_OFF)
                     s_next.mode = MODE_SLEEP;
               end
               else if (pwdata[1:0] == MODE_NORMAL)
                  s_next.mode = MODE_NORMAL;
            end
            default:
               s_next.mask = s_reg.mask;
         endcase
      end

      // Applied after the command decode so an alert wins over a start in the same cycle
      // (R7) protection checks follow new measurements only
      if (new_meas_valid)
      begin
         s_next.ov = cell_overvoltage;
         s_next.uv = cell_undervoltage;
         // (R10) alert disables balancing immediately
         if (cell_overvoltage || cell_undervoltage)
         begin
            s_next.bal  = BAL_OFF;
            s_next.mask = '0;
         end
      end

      // (R17) (R18) settle delay stalls the loop before a measuring round
      if (round_end)
      begin
         s_next.round = round_inc;
         if (settle_load)
            s_next.sched = SCH_SETTLE;
         if (next_meas)
            s_next.was_on = 1'b0;
      end
      if (s_reg.sched == SCH_SETTLE && settle_done)
         s_next.sched = SCH_RUN;
      // Any bypass-on cycle since the last measuring round arms the settle delay
      if (s_reg.bypass != '0)
         s_next.was_on = 1'b1;

      // (R5) skipped rounds keep their slot timing, as idle slots
      s_next.meas = run && cur_meas;
      s_next.idle = run && !cur_meas;

      // (R6) (R21) bypass off in measuring round, its lead-in slot and settle
      if (s_next.bal == BAL_ON && run && !cur_meas && !(slot_last && next_meas))
         s_next.bypass = s_next.mask;
      else
         s_next.bypass = '0;

      // (R15) (R16) flag ignores the short measurement pauses
      s_next.flag = (s_next.bal == BAL_ON);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg       <= '0;
         s_reg.skip  <= SKIP_RESET;
         s_reg.speed <= SPEED_RESET;
         s_reg.delay <= DELAY_RESET;
         s_reg.bal   <= BAL_OFF;
         s_reg.mode  <= MODE_NORMAL;
         s_reg.sched <= SCH_RUN;
      end
      else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata                = s_reg.prdata;
   assign pready                = s_reg.pready;
   assign pslverr               = s_reg.pslverr;
   assign bypass_en             = s_reg.bypass;
   assign measure_slot          = s_reg.meas;
   assign idle_slot             = s_reg.idle;
   assign power_mode            = s_reg.mode;
   assign balancing_active_flag = s_reg.flag;

endmodule

//--- verif/cell_balance_scheduler_props.sv
`timescale 1ns/1ns
module cell_balance_scheduler_props
   import cell_balance_pkg::*;
#(
   parameter int NUM_CELLS   = NUM_CELLS_DEF,
   parameter int SLOT_CYCLES = SLOT_CYCLES_DEF
)(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 new_meas_valid,
   input wire logic                 cell_overvoltage,
   input wire logic                 cell_undervoltage,
   input wire logic [NUM_CELLS-1:0] bypass_en,
   input wire logic                 measure_slot,
   input wire logic                 idle_slot,
   input wire logic [1:0]           power_mode,
   input wire logic                 balancing_active_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_meas_bypass_off:
      assert property (measure_slot |-> bypass_en == '0) else $error("bypass on in measuring slot");
   a_last_slot_off:
      assert property ($rose(measure_slot) |-> $past(bypass_en, SLOT_CYCLES) == '0)
      else $error("bypass on in slot before measuring");
   a_slot_kinds_excl:
      assert property (!(measure_slot && idle_slot)) else $error("slot both idle and measuring");
   a_alert_stops_bal:
      assert property (new_meas_valid && (cell_overvoltage || cell_undervoltage) && balancing_active_flag
                       |=> !balancing_active_flag && bypass_en == '0) else $error("alert left balancing on");
   a_no_sleep_bal:
      assert property (balancing_active_flag |-> power_mode != 2'h1) else $error("sleep while balancing");
   a_deep_ends_bal:
      assert property (power_mode == 2'h2 |=> !balancing_active_flag) else $error("balancing in deep mode");
   a_bypass_needs_flag:
      assert property (|bypass_en |-> balancing_active_flag) else $error("bypass on without flag");
   a_pready_one_wait:
      assert property (psel && penable && !$past(penable) |-> !pready ##1 pready ##1 !pready)
      else $error("pready timing wrong");
   a_err_with_ready:
      assert property (pslverr |-> pready) else $error("pslverr without pready");

   c_flag_rise: cover property ($rose(balancing_active_flag));
   c_idle_seen: cover property (idle_slot && |bypass_en);
   c_alert: cover property (new_meas_valid && cell_overvoltage && balancing_active_flag);
endmodule

//--- verif/meas_front_model.sv
`timescale 1ns/1ns
module meas_front_model
#(
   parameter int LAT = 2
)(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic measure_slot,
   input  wire logic want_ov,
   input  wire logic want_uv,
   output logic      new_meas_valid,
   output logic      cell_overvoltage,
   output logic      cell_undervoltage
);
   logic [7:0] pipe;
   logic       last;
   logic       tog;
   // one result per rise of measure_slot, LAT+1 cycles later, while measuring goes on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pipe <= '0;
         last <= 1'b0;
         tog  <= 1'b0;
      end
      else
      begin
         last <= measure_slot;
         pipe <= {pipe[6:0], measure_slot & ~last};
         tog  <= ~tog;
      end
   end
   assign new_meas_valid    = pipe[LAT];
   // Levels are meaningless outside a result, so they wander
   assign cell_overvoltage  = new_meas_valid ? want_ov : tog;
   assign cell_undervoltage = new_meas_valid ? want_uv : ~tog;
endmodule

//--- verif/cell_balance_scheduler_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module cell_balance_scheduler_tb_top;
   import cell_balance_pkg::*;
   localparam int SC  = 4;
   localparam int MSC = 4;
   localparam int TO  = 4000;
   typedef struct {logic [1:0] skip; logic [1:0] speed; logic [2:0] dly; bit bal;} row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        new_meas_valid, cell_overvoltage, cell_undervoltage, measure_slot, idle_slot;
   logic        balancing_active_flag, want_ov, want_uv, was_meas;
   logic [1:0]  power_mode;
   logic [6:0]  bypass_en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          miscompares, n_compared, gap_cnt, gap_len, idle_cnt, gap_idle, n_rise, exp_len;
   int          settle_tab[8] = '{0, 1, 2, 4, 8, 16, 32, 64};
   row_s        rows[8] = '{'{0, 1, 0, 0}, '{0, 2, 0, 0}, '{0, 0, 0, 1}, '{1, 0, 0, 1},
                            '{2, 0, 0, 1}, '{3, 0, 0, 1}, '{0, 3, 7, 1}, '{1, 0, 3, 1}};

   cell_balance_scheduler #(.SLOT_CYCLES(SC), .TIMEOUT_CYC(TO), .MS_CYC(MSC)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .new_meas_valid(new_meas_valid), .cell_overvoltage(cell_overvoltage),
      .cell_undervoltage(cell_undervoltage), .bypass_en(bypass_en), .measure_slot(measure_slot),
      .idle_slot(idle_slot), .power_mode(power_mode), .balancing_active_flag(balancing_active_flag));
   meas_front_model #(.LAT(2)) u_meas (
      .pclk(pclk), .presetn(presetn), .measure_slot(measure_slot), .want_ov(want_ov),
      .want_uv(want_uv), .new_meas_valid(new_meas_valid), .cell_overvoltage(cell_overvoltage),
      .cell_undervoltage(cell_undervoltage));

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Measuring-round spacing and idle cycles between rises
   always @(posedge pclk)
   begin
      was_meas <= measure_slot;
      if (measure_slot === 1'b1 && was_meas === 1'b0)
      begin
         gap_len  <= gap_cnt;
         gap_idle <= idle_cnt;
         n_rise   <= n_rise + 1;
         gap_cnt  <= 1;
         idle_cnt <= 0;
      end
      else
      begin
         gap_cnt  <= gap_cnt + 1;
         idle_cnt <= idle_cnt + int'(idle_slot === 1'b1);
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No local limit: only the watchdog ends a stalled transfer
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_flag(input logic v, input int lim);
      int n;
      n = 0;
      while (balancing_active_flag !== v && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim)
         miscompares++;
   endtask

   task automatic wait_rise(input int k);
      int s;
      int n;
      s = n_rise;
      n = 0;
      while (n_rise < s + k && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000)
         miscompares++;
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, want_ov, want_uv, presetn} = '0;
      {miscompares, n_compared, gap_cnt, idle_cnt, n_rise} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_ALARM, 0);
      `CHK(rd, 32'h0000_0000)
      $display("reset test done");
      foreach (rows[i])
      begin
         apb(1, OFS_CONFIG, {25'h0, rows[i].dly, rows[i].speed, rows[i].skip});
         if (rows[i].bal)
            apb(1, OFS_BAL_CMD, 32'h0000_0055);
         wait_rise(3);
         exp_len = rows[i].bal ? (2 << rows[i].skip) * 8 * SC + settle_tab[rows[i].dly] * MSC
                               : (1 << rows[i].speed) * 8 * SC;
         `CHK(gap_len, exp_len)
         if (rows[i].bal && rows[i].dly == 0)
            `CHK(gap_idle, exp_len - 8 * SC)
         `CHK(balancing_active_flag, logic'(rows[i].bal))
         apb(1, OFS_BAL_CMD, 0);
         wait_flag(0, 100);
         `CHK(balancing_active_flag, 1'b0)
         $display("row %0d done", i);
      end
      apb(1, OFS_CONFIG, 32'h0000_0004);
      wait_rise(1);
      apb(1, OFS_BAL_CMD, 32'h0000_002a);
      apb(0, OFS_BAL_CMD, 0);
      `CHK(rd, 32'h0000_002a)
      apb(0, OFS_ALARM, 0);
      `CHK(rd[1:0], 2'b10)
      wait_flag(1, 100);
      `CHK(balancing_active_flag, 1'b1)
      apb(1, OFS_MODE, 1);
      apb(0, OFS_MODE, 0);
      `CHK(rd, 32'h0000_0000)
      $display("start test done");
      for (int k = 0; k < 2; k++)
      begin
         apb(1, OFS_BAL_CMD, 32'h0000_0011);
         wait_flag(1, 100);
         want_ov <= (k == 0);
         want_uv <= (k == 1);
         wait_flag(0, 600);
         `CHK(balancing_active_flag, 1'b0)
         apb(0, OFS_BAL_CMD, 0);
         `CHK(rd, 32'h0000_0000)
         want_ov <= 1'b0;
         want_uv <= 1'b0;
      end
      $display("alert test done");
      apb(1, OFS_MODE, 1);
      apb(0, OFS_MODE, 0);
      `CHK(rd, 32'h0000_0001)
      `CHK(power_mode, 2'h1)
      apb(1, OFS_BAL_CMD, 32'h0000_007f);
      apb(0, OFS_MODE, 0);
      `CHK(rd, 32'h0000_0000)
      `CHK(power_mode, 2'h0)
      wait_flag(1, 100);
      apb(1, OFS_MODE, 2);
      repeat (2) @(posedge pclk);
      `CHK(balancing_active_flag, 1'b0)
      `CHK(bypass_en, 7'h00)
      `CHK(power_mode, 2'h2)
      apb(1, OFS_BAL_CMD, 32'h0000_0001);
      repeat (100) @(posedge pclk);
      apb(0, OFS_ALARM, 0);
      `CHK(rd[1:0], 2'b00)
      apb(1, OFS_MODE, 0);
      $display("mode test done");
      apb(1, OFS_BAL_CMD, 32'h0000_0003);
      wait_flag(1, 100);
      repeat (3000) @(posedge pclk);
      apb(1, OFS_BAL_CMD, 32'h0000_0003);
      repeat (3000) @(posedge pclk);
      `CHK(balancing_active_flag, 1'b1)
      wait_flag(0, 1500);
      `CHK(balancing_active_flag, 1'b0)
      apb(0, 8'h10, 0);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      apb(1, 8'h14, 32'hffff_ffff);
      `CHK(err, 1'b1)
      $display("timer and error test done");
      // Reset in mid-run, with balancing on
      apb(1, OFS_BAL_CMD, 32'h0000_0005);
      wait_flag(1, 100);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      `CHK({balancing_active_flag, bypass_en, power_mode}, 10'h000)
      presetn <= 1'b1;
      apb(0, OFS_BAL_CMD, 0);
      `CHK(rd, 32'h0000_0000)
      $display("mid-run reset test done");
      stop_test();
   end

   initial
   begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      stop_test();
   end
endmodule

bind cell_balance_scheduler cell_balance_scheduler_props #(.NUM_CELLS(NUM_CELLS), .SLOT_CYCLES(SLOT_CYCLES)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .new_meas_valid(new_meas_valid), .cell_overvoltage(cell_overvoltage),
   .cell_undervoltage(cell_undervoltage), .bypass_en(bypass_en), .measure_slot(measure_slot),
   .idle_slot(idle_slot), .power_mode(power_mode), .balancing_active_flag(balancing_active_flag));
